/* File: hdl/lmws_list_seq.sv */
// list mode waveform sequencer: AXI4-Lite registers, three segment stores, run control
// assumes synchronous inputs, one 250 MHz clock, wave_cycle_in pulses once per output cycle
`timescale 1ns/1ps
`default_nettype none
`include "lmws_defines.svh"

module lmws_list_seq
  import lmws_pkg::*;
#(
  parameter int unsigned TIME_UNIT_CYC = `LMWS_TIME_UNIT_CYC
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_trig_in,
  input  wire logic        wave_cycle_in,
  input  wire logic [15:0] cur_angle_in [`LMWS_NPHASE],
  output logic             running,
  output logic             out_en,
  output logic             base_only,
  output logic             seg_start,
  output logic [6:0]       seg_index,
  output logic [15:0]      ph_ac    [`LMWS_NPHASE],
  output logic [15:0]      ph_freq  [`LMWS_NPHASE],
  output logic [15:0]      ph_dc    [`LMWS_NPHASE],
  output logic [15:0]      ph_angle [`LMWS_NPHASE],
  output logic             ph_shape [`LMWS_NPHASE]
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [5:0]   ctrl_q;
  logic [15:0]  count_q;
  logic [6:0]   segsel_idx_q;
  logic [1:0]   segsel_ph_q;
  logic         bvalid_q;
  logic [1:0]   bresp_q;
  logic         rvalid_q;
  logic [31:0]  rdata_q;
  logic [1:0]   rresp_q;
  logic         page_prev_q;
  logic         ext_prev_q;
  lmws_state_e  state_q;
  logic [6:0]   seg_q;
  logic [15:0]  pass_q;
  logic [15:0]  elapsed_q;
  logic [31:0]  presc_q;
  logic         out_en_q;
  logic         seg_start_q;

  logic         aw_hs;
  logic [7:0]   fld_off;
  logic         fld_hit;
  logic         wr_ctrl;
  logic         wr_count;
  logic         wr_cmd;
  logic         wr_segsel;
  logic         wr_mapped;
  logic         cmd_trig;
  logic         cmd_stop;
  logic         cmd_toggle;
  lmws_trig_e   tmode;
  logic         page_q;
  logic         page_fall;
  logic         ext_rise;
  logic [15:0]  eff_count;
  logic [15:0]  pass_n;
  logic [15:0]  dur;
  logic         unit_tick;
  logic         seg_done;
  logic         pass_done;
  logic         finish;
  logic         abort;
  logic         start_req;
  logic         load_ok;
  logic         enter_last;
  lmws_seg_s    seq_ent [`LMWS_NPHASE];
  lmws_seg_s    bus_ent [`LMWS_NPHASE];
  lmws_seg_s    src     [`LMWS_NPHASE];
  lmws_seg_s    rd_ent;
  logic [7:0]   rd_off;

  function automatic logic [15:0] ang_add(input logic [15:0] a, input logic [16:0] off);
    logic [16:0] s;
    s = {1'b0, a} + off;
    if (s >= `LMWS_ANG_FULL)
    begin
      s = s - `LMWS_ANG_FULL;
    end
    ang_add = s[15:0];
  endfunction : ang_add

  function automatic logic [15:0] fld_get(input lmws_seg_s e, input logic [3:0] f);
    unique case (f)
      `LMWS_FLD_AC_START: fld_get = e.ac_start;
      `LMWS_FLD_AC_END:   fld_get = e.ac_end;
      `LMWS_FLD_F_START:  fld_get = e.f_start;
      `LMWS_FLD_F_END:    fld_get = e.f_end;
      `LMWS_FLD_DC_START: fld_get = e.dc_start;
      `LMWS_FLD_DC_END:   fld_get = e.dc_end;
      `LMWS_FLD_ANGLE:    fld_get = e.angle;
      `LMWS_FLD_DUR:      fld_get = e.dur;
      `LMWS_FLD_SHAPE:    fld_get = {15'h0000, e.shape};
      default:            fld_get = 16'h0000;
    endcase
  endfunction : fld_get

  ////////////////////////////////////////////////////////////////////////////////
  // segment stores, one per phase

  lmws_seg_if seg_if [`LMWS_NPHASE] ();

  for (genvar g = 0; g < `LMWS_NPHASE; g++)
  begin : g_ph
    assign seg_if[g].wr_en    = aw_hs && fld_hit && (s_axi_wstrb[1:0] == 2'h3)
                                && (segsel_ph_q == 2'(g));
    assign seg_if[g].wr_idx   = segsel_idx_q;
    assign seg_if[g].wr_field = fld_off[5:2];
    assign seg_if[g].wr_data  = s_axi_wdata[15:0];
    assign seg_if[g].seq_idx  = seg_q;
    assign seg_if[g].bus_idx  = segsel_idx_q;
    assign seq_ent[g]         = seg_if[g].seq_ent;
    assign bus_ent[g]         = seg_if[g].bus_ent;
    assign src[g]             = ctrl_q[`LMWS_CTRL_COUPLE] ? seq_ent[0] : seq_ent[g];

    lmws_seg_store u_store (
      .aclk    (aclk),
      .aresetn (aresetn),
      .seg     (seg_if[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign aw_hs         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = aw_hs;
  assign s_axi_wready  = aw_hs;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign fld_off   = s_axi_awaddr - `LMWS_OFF_FLD0;
  assign fld_hit   = (s_axi_awaddr >= `LMWS_OFF_FLD0) && (s_axi_awaddr <= `LMWS_OFF_FLDN)
                     && (s_axi_awaddr[1:0] == 2'h0);
  assign wr_ctrl   = aw_hs && (s_axi_awaddr == `LMWS_OFF_CTRL);
  assign wr_count  = aw_hs && (s_axi_awaddr == `LMWS_OFF_COUNT);
  assign wr_cmd    = aw_hs && (s_axi_awaddr == `LMWS_OFF_CMD) && s_axi_wstrb[0];
  assign wr_segsel = aw_hs && (s_axi_awaddr == `LMWS_OFF_SEGSEL);
  assign wr_mapped = fld_hit || (s_axi_awaddr == `LMWS_OFF_CTRL)
                     || (s_axi_awaddr == `LMWS_OFF_COUNT) || (s_axi_awaddr == `LMWS_OFF_CMD)
                     || (s_axi_awaddr == `LMWS_OFF_STATUS) || (s_axi_awaddr == `LMWS_OFF_SEGSEL);

  assign cmd_trig   = wr_cmd && s_axi_wdata[`LMWS_CMD_TRIG];
  assign cmd_stop   = wr_cmd && s_axi_wdata[`LMWS_CMD_STOP];
  assign cmd_toggle = wr_cmd && s_axi_wdata[`LMWS_CMD_TOGGLE];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `LMWS_RESP_OKAY;
    end
    else if (aw_hs)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? `LMWS_RESP_OKAY : `LMWS_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q       <= `LMWS_CTRL_RST;
      count_q      <= `LMWS_COUNT_RST;
      segsel_idx_q <= 7'h00;
      segsel_ph_q  <= 2'h0;
    end
    else
    begin
      if (wr_ctrl && s_axi_wstrb[0])
      begin
        ctrl_q <= s_axi_wdata[5:0];
      end
      if (wr_count && s_axi_wstrb[0])
      begin
        count_q[7:0] <= s_axi_wdata[7:0];
      end
      if (wr_count && s_axi_wstrb[1])
      begin
        count_q[15:8] <= s_axi_wdata[15:8];
      end
      if (wr_segsel && (s_axi_wstrb[1:0] == 2'h3) && (s_axi_wdata[6:0] <= `LMWS_SEG_LAST)
          && (s_axi_wdata[9:8] < 2'h3))
      begin
        segsel_idx_q <= s_axi_wdata[6:0];
        segsel_ph_q  <= s_axi_wdata[9:8];
      end
    end
  end

  assign rd_off = s_axi_araddr - `LMWS_OFF_FLD0;
  assign rd_ent = bus_ent[segsel_ph_q];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `LMWS_RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= `LMWS_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      if (s_axi_araddr == `LMWS_OFF_CTRL)
        rdata_q <= {26'h0000000, ctrl_q};
      else if (s_axi_araddr == `LMWS_OFF_COUNT)
        rdata_q <= {16'h0000, count_q};
      else if (s_axi_araddr == `LMWS_OFF_STATUS)
        rdata_q <= {pass_q, 1'b0, seg_q, 5'h00, base_only, out_en_q, running};
      else if (s_axi_araddr == `LMWS_OFF_SEGSEL)
        rdata_q <= {22'h000000, segsel_ph_q, 1'b0, segsel_idx_q};
      else if ((s_axi_araddr >= `LMWS_OFF_FLD0) && (s_axi_araddr <= `LMWS_OFF_FLDN)
               && (s_axi_araddr[1:0] == 2'h0))
        rdata_q <= {16'h0000, fld_get(rd_ent, rd_off[5:2])};
      else if (s_axi_araddr != `LMWS_OFF_CMD)
        rresp_q <= `LMWS_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // trigger, stop and pass bookkeeping

  assign tmode     = lmws_trig_e'(ctrl_q[1:0]);
  assign page_q    = ctrl_q[`LMWS_CTRL_PAGE];
  assign page_fall = page_prev_q && !page_q;
  assign ext_rise  = ext_trig_in && !ext_prev_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      page_prev_q <= 1'b0;
      ext_prev_q  <= 1'b0;
    end
    else
    begin
      page_prev_q <= page_q;
      ext_prev_q  <= ext_trig_in;
    end
  end

  assign eff_count  = (tmode == LMWS_TRIG_MANUAL) ? 16'h0001 : count_q;
  assign pass_n     = pass_q + 16'h0001;
  assign dur        = seq_ent[0].dur;
  assign unit_tick  = ctrl_q[`LMWS_CTRL_BASE] ? wave_cycle_in
                                              : (presc_q == 32'(TIME_UNIT_CYC - 1));
  assign seg_done   = (state_q == ST_PLAY) && unit_tick && ((elapsed_q + 16'h0001) == dur);
  assign enter_last = (state_q == ST_PLAY) && unit_tick && ((elapsed_q + 16'h0002) == dur);
  assign pass_done  = ((state_q == ST_LOAD) && (dur == 16'h0000))
                      || (seg_done && (seg_q == `LMWS_SEG_LAST));
  assign finish     = pass_done && (((eff_count != 16'h0000) && (pass_n == eff_count))
                      || ((state_q == ST_LOAD) && (seg_q == 7'h00)));
  assign abort      = cmd_stop || (cmd_toggle && out_en_q) || page_fall;
  assign start_req  = (state_q == ST_STOP) && page_q && !abort
                      && ((tmode == LMWS_TRIG_EXT) ? ext_rise : cmd_trig);
  assign load_ok    = (state_q == ST_LOAD) && (dur != 16'h0000) && !abort;

  ////////////////////////////////////////////////////////////////////////////////
  // run state

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= ST_STOP;
    else if (abort || finish)
      state_q <= ST_STOP;
    else
    begin
      unique case (state_q)
        ST_STOP: if (start_req) state_q <= ST_LOAD;
        ST_LOAD: if (dur != 16'h0000) state_q <= ST_PLAY;
        ST_PLAY: if (seg_done) state_q <= ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seg_q <= 7'h00;
    else if (start_req || pass_done || abort)
      seg_q <= 7'h00;
    else if (seg_done)
      seg_q <= seg_q + 7'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pass_q <= 16'h0000;
    else if (start_req)
      pass_q <= 16'h0000;
    else if (pass_done && !finish)
      pass_q <= pass_n;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      elapsed_q <= 16'h0000;
    else if (state_q != ST_PLAY)
      elapsed_q <= 16'h0000;
    else if (unit_tick)
      elapsed_q <= elapsed_q + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      presc_q <= 32'h0000_0000;
    else if ((state_q != ST_PLAY) || (presc_q == 32'(TIME_UNIT_CYC - 1)))
      presc_q <= 32'h0000_0000;
    else
      presc_q <= presc_q + 32'h0000_0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_en_q <= 1'b0;
    else if (abort || finish)
      out_en_q <= 1'b0;
    else if (start_req || cmd_toggle)
      out_en_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seg_start_q <= 1'b0;
    else
      seg_start_q <= load_ok;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-phase output values

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int p = 0; p < `LMWS_NPHASE; p++)
      begin
        ph_ac[p] <= 16'h0000;
        ph_freq[p] <= 16'h0000;
        ph_dc[p] <= 16'h0000;
        ph_angle[p] <= 16'h0000;
        ph_shape[p] <= 1'b0;
      end
    end
    else
    begin
      for (int p = 0; p < `LMWS_NPHASE; p++)
      begin
        if (abort || finish)
        begin
          ph_ac[p] <= 16'h0000;
          ph_dc[p] <= 16'h0000;
        end
        else if (load_ok)
        begin
          ph_ac[p] <= src[p].ac_start;
          ph_freq[p] <= src[p].f_start;
          ph_dc[p] <= src[p].dc_start;
          ph_shape[p] <= src[p].shape;
          if (ctrl_q[`LMWS_CTRL_PCONT] && ((seg_q != 7'h00) || (pass_q != 16'h0000)))
            ph_angle[p] <= cur_angle_in[p];
          else if ((seg_q == 7'h00) && (p != 0))
            ph_angle[p] <= ang_add(seq_ent[0].angle, (p == 1) ? `LMWS_ANG_120
                                                               : (`LMWS_ANG_120 << 1));
          else
            ph_angle[p] <= src[p].angle;
        end
        else if (enter_last && !abort)
        begin
          ph_ac[p] <= src[p].ac_end;
          ph_freq[p] <= src[p].f_end;
          ph_dc[p] <= src[p].dc_end;
        end
      end
    end
  end

  assign running   = (state_q != ST_STOP);
  assign out_en    = out_en_q;
  assign base_only = out_en_q && (state_q == ST_STOP);
  assign seg_start = seg_start_q;
  assign seg_index = seg_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence trig_s;
    (state_q == ST_STOP) && start_req;
  endsequence

  sequence seg0_load_s;
    (state_q == ST_LOAD) && (seg_q == 7'h00) && load_ok && !finish;
  endsequence

  run_on_trigger_a: assert property (trig_s |=> running && out_en ##1 seg_q == 7'h00)
    else $error("trigger did not start the list");
  stop_halts_a: assert property (cmd_stop && running |=> !running && !out_en)
    else $error("stop did not end the list");
  toggle_zero_a: assert property (cmd_toggle && out_en |=> !out_en && ph_ac[0] == 16'h0000 && ph_dc[0] == 16'h0000)
    else $error("toggle did not zero the output");
  toggle_base_a: assert property (cmd_toggle && !out_en && !running && !cmd_stop |=> base_only)
    else $error("second toggle did not give base waveform");
  finish_quit_a: assert property (finish && !abort |=> !running && !out_en)
    else $error("list end did not stop and disable output");
  retrig_ignored_a: assert property (running && cmd_trig && !abort && !seg_done && !pass_done |=> $stable(seg_q) && $stable(pass_q))
    else $error("trigger disturbed a running list");
  seg_range_a: assert property (seg_q <= `LMWS_SEG_LAST)
    else $error("segment index beyond 99");
  manual_once_a: assert property ((tmode == LMWS_TRIG_MANUAL) && pass_done && !abort |=> !running)
    else $error("manual trigger played more than once");
  page_exit_a: assert property (page_fall |=> !running && !out_en)
    else $error("page exit left the list active");
  seg0_offset_a: assert property ((seg0_load_s and !ctrl_q[`LMWS_CTRL_PCONT])
    |=> ph_angle[1] == ang_add(ph_angle[0], `LMWS_ANG_120))
    else $error("segment zero phase offset wrong");

endmodule : lmws_list_seq

`default_nettype wire

/* File: hdl/lmws_defines.svh */
// register offsets, field positions, reset values and timing counts of the list sequencer
// assumes a 250 MHz system clock and a byte-addressed AXI4-Lite register window
`ifndef LMWS_DEFINES_SVH
`define LMWS_DEFINES_SVH

`define LMWS_OFF_CTRL       8'h00
`define LMWS_OFF_COUNT      8'h04
`define LMWS_OFF_CMD        8'h08
`define LMWS_OFF_STATUS     8'h0c
`define LMWS_OFF_SEGSEL     8'h10
`define LMWS_OFF_FLD0       8'h14
`define LMWS_OFF_FLDN       8'h34

`define LMWS_CTRL_TMODE     0
`define LMWS_CTRL_COUPLE    2
`define LMWS_CTRL_PCONT     3
`define LMWS_CTRL_BASE      4
`define LMWS_CTRL_PAGE      5
`define LMWS_CTRL_RST       6'h00
`define LMWS_COUNT_RST      16'h0001

`define LMWS_CMD_TRIG       0
`define LMWS_CMD_STOP       1
`define LMWS_CMD_TOGGLE     2

`define LMWS_SEGSEL_PH      8

`define LMWS_FLD_AC_START   4'h0
`define LMWS_FLD_AC_END     4'h1
`define LMWS_FLD_F_START    4'h2
`define LMWS_FLD_F_END      4'h3
`define LMWS_FLD_DC_START   4'h4
`define LMWS_FLD_DC_END     4'h5
`define LMWS_FLD_ANGLE      4'h6
`define LMWS_FLD_DUR        4'h7
`define LMWS_FLD_SHAPE      4'h8

`define LMWS_SEG_LAST       7'h63
`define LMWS_NSEG           100
`define LMWS_NPHASE         3
`define LMWS_ANG_120        17'h004b0
`define LMWS_ANG_FULL       17'h00e10

`define LMWS_CLK_NS         4
`define LMWS_TIME_UNIT_NS   100000
`define LMWS_TIME_UNIT_CYC  (`LMWS_TIME_UNIT_NS / `LMWS_CLK_NS)

`define LMWS_RESP_OKAY      2'h0
`define LMWS_RESP_SLVERR    2'h2

`endif

/* File: hdl/lmws_pkg.sv */
// types shared by the list sequencer, its segment store and their interface
// assumes lmws_defines.svh is on the include path
`include "lmws_defines.svh"

package lmws_pkg;

  typedef enum logic [1:0] {LMWS_TRIG_AUTO, LMWS_TRIG_MANUAL, LMWS_TRIG_EXT} lmws_trig_e;

  typedef enum logic [1:0] {ST_STOP, ST_LOAD, ST_PLAY} lmws_state_e;

  typedef struct packed {
    logic [15:0] ac_start;
    logic [15:0] ac_end;
    logic [15:0] f_start;
    logic [15:0] f_end;
    logic [15:0] dc_start;
    logic [15:0] dc_end;
    logic [15:0] angle;
    logic [15:0] dur;
    logic        shape;
  } lmws_seg_s;

endpackage : lmws_pkg

/* File: hdl/lmws_seg_if.sv */
// write port and two read ports of one phase's segment store
// assumes one instance per phase, all in the aclk domain
`timescale 1ns/1ps
`default_nettype none

interface lmws_seg_if;
  import lmws_pkg::*;
  logic             wr_en;
  logic [6:0]       wr_idx;
  logic [3:0]       wr_field;
  logic [15:0]      wr_data;
  logic [6:0]       seq_idx;
  logic [6:0]       bus_idx;
  lmws_seg_s        seq_ent;
  lmws_seg_s        bus_ent;

  modport ctl   (output wr_en, wr_idx, wr_field, wr_data, seq_idx, bus_idx,
                 input seq_ent, bus_ent);
  modport store (input wr_en, wr_idx, wr_field, wr_data, seq_idx, bus_idx,
                 output seq_ent, bus_ent);
endinterface : lmws_seg_if

`default_nettype wire

/* File: hdl/lmws_seg_store.sv */
// segment parameter store of one phase, segments 0 to 99
// assumes indices never exceed 99; the sequencer guarantees it
`timescale 1ns/1ps
`default_nettype none
`include "lmws_defines.svh"

module lmws_seg_store
  import lmws_pkg::*;
(
  input wire logic    aclk,
  input wire logic    aresetn,
  lmws_seg_if.store   seg
);

  lmws_seg_s mem [`LMWS_NSEG];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < `LMWS_NSEG; i++)
      begin
        mem[i] <= '0;
      end
    end
    else if (seg.wr_en)
    begin
      unique case (seg.wr_field)
        `LMWS_FLD_AC_START: mem[seg.wr_idx].ac_start <= seg.wr_data;
        `LMWS_FLD_AC_END:   mem[seg.wr_idx].ac_end   <= seg.wr_data;
        `LMWS_FLD_F_START:  mem[seg.wr_idx].f_start  <= seg.wr_data;
        `LMWS_FLD_F_END:    mem[seg.wr_idx].f_end    <= seg.wr_data;
        `LMWS_FLD_DC_START: mem[seg.wr_idx].dc_start <= seg.wr_data;
        `LMWS_FLD_DC_END:   mem[seg.wr_idx].dc_end   <= seg.wr_data;
        `LMWS_FLD_ANGLE:    mem[seg.wr_idx].angle    <= seg.wr_data;
        `LMWS_FLD_DUR:      mem[seg.wr_idx].dur      <= seg.wr_data;
        `LMWS_FLD_SHAPE:    mem[seg.wr_idx].shape    <= seg.wr_data[0];
        default:            mem[seg.wr_idx].shape    <= mem[seg.wr_idx].shape;
      endcase
    end
  end

  assign seg.seq_ent = mem[seg.seq_idx];
  assign seg.bus_ent = mem[seg.bus_idx];

endmodule : lmws_seg_store

`default_nettype wire

/* File: testbench/lmws_far_side.sv */
// far side model: external trigger line, cycle ticks, present angles
// assumes aclk from the bench; fire asks for one trigger pulse
`timescale 1ns/1ps
`default_nettype none
`include "lmws_defines.svh"
module lmws_far_side
(
  input  wire logic   aclk,
  input  wire logic   fire,
  output logic        ext_trig_in = 1'b0,
  output logic        wave_cycle_in = 1'b0,
  output logic [15:0] cur_angle_in [`LMWS_NPHASE]
);
  logic [2:0] tick_q = 3'h0;
  always_ff @(posedge aclk)
  begin
    ext_trig_in <= fire;
    tick_q <= tick_q + 3'h1;
    wave_cycle_in <= (tick_q == 3'h7);
  end
  always_comb
  begin
    for (int i = 0; i < `LMWS_NPHASE; i++)
      cur_angle_in[i] = 16'(100 * i + 50);
  end
endmodule : lmws_far_side
`default_nettype wire

/* File: testbench/tb.sv */
// bench: register traffic, list runs, stop, toggle, page exit, external trigger
// assumes the far side model drives the trigger line and cycle ticks
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0, fire = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        ext_trig_in, wave_cycle_in, running, out_en, base_only, seg_start;
  logic [6:0]  seg_index;
  logic [15:0] cur_angle_in [3], ph_ac [3], ph_freq [3], ph_dc [3], ph_angle [3];
  logic        ph_shape [3];
  int          n_fail = 0, samples_checked = 0;
  lmws_list_seq #(.TIME_UNIT_CYC(4)) lmws_list_seq_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trig_in, .wave_cycle_in,
    .cur_angle_in, .running, .out_en, .base_only, .seg_start, .seg_index, .ph_ac, .ph_freq,
    .ph_dc, .ph_angle, .ph_shape);
  lmws_far_side lmws_far_side_i (.aclk, .fire, .ext_trig_in, .wave_cycle_in, .cur_angle_in);
  task automatic tally_and_finish();
    $display("checked %0d bad %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask : ck
  task automatic wt(ref logic s, input logic v);
    for (int k = 0; s !== v; k++)
    begin
      if (k > 999)
      begin
        n_fail++;
        tally_and_finish();
      end
      @(negedge aclk);
    end
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    @(negedge aclk);
    wt(s_axi_awready, 1'b1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(negedge aclk);
    wt(s_axi_bvalid, 1'b1);
    rr = s_axi_bresp;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(negedge aclk);
    wt(s_axi_arready, 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(negedge aclk);
    wt(s_axi_rvalid, 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
  endtask : rd
  task automatic t_reg();
    rd(8'h0c);
    ck(rv, 32'h0);
    wr(8'h10, 32'h64);
    rd(8'h10);
    ck(rv, 32'h0);
    rd(8'hfc);
    ck(rr, 2'h2);
    $display("reg done");
  endtask : t_reg
  task automatic t_runs();
    wr(8'h30, 32'h2);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h21);
    wr(8'h08, 32'h1);
    @(negedge aclk);
    ck(running, 1'b1);
    wt(running, 1'b0);
    ck(out_en, 1'b0);
    rd(8'h0c);
    // status counts the passes before the last one
    ck(rv[31:16], 32'h0);
    wr(8'h00, 32'h20);
    wr(8'h08, 32'h1);
    wr(8'h08, 32'h1);
    @(negedge aclk);
    ck(running, 1'b1);
    wt(running, 1'b0);
    rd(8'h0c);
    ck(rv[31:16], 32'h2);
    $display("runs done");
  endtask : t_runs
  task automatic t_stop();
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h1);
    repeat (80) @(negedge aclk);
    ck(running, 1'b1);
    wr(8'h08, 32'h2);
    @(negedge aclk);
    ck(out_en, 1'b0);
    wr(8'h08, 32'h1);
    wr(8'h08, 32'h4);
    @(negedge aclk);
    ck(out_en, 1'b0);
    wr(8'h08, 32'h4);
    @(negedge aclk);
    ck(base_only, 1'b1);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h0);
    repeat (2) @(negedge aclk);
    ck(running, 1'b0);
    $display("stop done");
  endtask : t_stop
  task automatic t_ext();
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h22);
    wr(8'h08, 32'h1);
    @(negedge aclk);
    ck(running, 1'b0);
    @(posedge aclk);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    wt(running, 1'b1);
    wt(running, 1'b0);
    ck(out_en, 1'b0);
    $display("ext done");
  endtask : t_ext
  task automatic t_seg();
    logic seen;
    int   n;
    seen = 1'b0;
    n = 0;
    wr(8'h14, 32'h100);
    wr(8'h18, 32'h200);
    wr(8'h2c, 32'h64);
    wr(8'h34, 32'h1);
    wr(8'h00, 32'h35);
    wr(8'h08, 32'h1);
    @(negedge aclk);
    ck(seg_start, 1'b1);
    ck(seg_index, 32'h0);
    ck(ph_ac[1], 32'h100);
    ck(ph_angle[0], 32'h64);
    ck(ph_angle[1], 32'h514);
    ck(ph_angle[2], 32'h9c4);
    ck(ph_shape[2], 1'b1);
    while (running && n < 40)
    begin
      seen = seen | (ph_ac[0] === 16'h0200);
      n++;
      @(negedge aclk);
    end
    ck(seen, 1'b1);
    ck(n >= 10 && n <= 17, 1'b1);
    ck(ph_ac[0], 32'h0);
    $display("seg done");
  endtask : t_seg
  initial
  begin
    forever #2 aclk = ~aclk;
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reg();
    t_runs();
    t_stop();
    t_ext();
    t_seg();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
